// ===== logic/lnbi2c_pkg.sv
// Constants, field layout and state codes for the dual LNB I2C control pair.
// Assumes a 100 MHz ref_clk on both ends and an open-drain two-wire link.
// Contract
// - Start, address with direction, data, acknowledge, stop
// - Answer 0001000 pin low, 0001001 pin high
// - Data MSB picks channel one or two register
// - Channel one register field order, overload read-only
// - Channel two register field order, two read-only flags
// - Compensation and voltage bits give 13/18/14/19 V
// - Tone follows pin, or forced on by bit
// - Limit bit high static clamp, low dynamic
// - Enable low turns converter and regulator off
// - Read address sends register byte MSB first
// - Master ack continues read, no ack ends
// - Writable bits read back as last written
// - Fault flags read one while protection active
// - Power-on clears every register bit
// - Power-good low: ignore bus, registers zero
// - Master sets enable with or after settings
// - No acknowledge while power-good low
// - Overheat sets flag and clears control data
// - Current-level bit picks low or high limit
// - High-volt pin forces 18 V output

`default_nettype none

package lnbi2c_pkg;

	// ----------------------------------------------------------------
	// Link addressing
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_PIN_LOW = 7'h08;
	localparam logic [6:0] ADDR_PIN_HIGH = 7'h09;

	// ----------------------------------------------------------------
	// Channel one register fields
	// ----------------------------------------------------------------
	localparam int R1_SEL = 7;
	localparam int R1_STATIC = 6;
	localparam int R1_ISEL = 5;
	localparam int R1_TONE = 4;
	localparam int R1_COMP = 3;
	localparam int R1_VPICK = 2;
	localparam int R1_ON = 1;
	localparam int R1_LOW_WR = 1;

	// ----------------------------------------------------------------
	// Channel two register fields
	// ----------------------------------------------------------------
	localparam int R2_SEL = 7;
	localparam int R2_ISEL = 6;
	localparam int R2_TONE = 5;
	localparam int R2_COMP = 4;
	localparam int R2_VPICK = 3;
	localparam int R2_ON = 2;
	localparam int R2_LOW_WR = 2;
	localparam int SEL_BIT = 7;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] VOUT_18V = 2'h1;

	// ----------------------------------------------------------------
	// Controller register port
	// ----------------------------------------------------------------
	localparam logic [3:0] HREG_CMD = 4'h0;
	localparam logic [3:0] HREG_STAT = 4'h4;
	localparam logic [3:0] HREG_RDATA = 4'h8;
	localparam int CMD_ABYTE_LSB = 0;
	localparam int CMD_WDATA_LSB = 8;
	localparam int CMD_RCNT_LSB = 16;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;

	// ----------------------------------------------------------------
	// Timing and bit cell
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_PERIOD_NS = 10000;
	localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [3:0] LAST_BIT_IDX = 4'h8;
	localparam logic [2:0] BYTE_LAST_CNT = 3'h7;
	localparam logic [1:0] Q_DRIVE = 2'h0;
	localparam logic [1:0] Q_RISE = 2'h1;
	localparam logic [1:0] Q_SAMPLE = 2'h2;
	localparam logic [1:0] Q_FALL = 2'h3;

	// ----------------------------------------------------------------
	// State codes
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		D_IDLE = 7'h01,
		D_ADDR = 7'h02,
		D_AACK = 7'h04,
		D_WR = 7'h08,
		D_WACK = 7'h10,
		D_RD = 7'h20,
		D_RACK = 7'h40
	} lnbi2c_dev_state_e;

	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_START = 5'h02,
		H_SEND = 5'h04,
		H_RECV = 5'h08,
		H_STOP = 5'h10
	} lnbi2c_host_state_e;

endpackage

`default_nettype wire

// ===== logic/lnbi2c_if.sv
// Two-wire link between controller and LNB supply device.
// Assumes open-drain lines with pull-ups; an enable pulls its line low.
`timescale 1ns/1ns
`default_nettype none

interface lnbi2c_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND of both ends on sda, host alone on scl, pull-up when nobody drives
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host (
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe,
		input sda
	);

	modport device (
		input scl,
		input sda,
		output dev_sda_o,
		output dev_sda_oe
	);
endinterface

`default_nettype wire

// ===== logic/lnbi2c_dev.sv
// Device end: I2C slave with two 8-bit control/status registers.
// Assumes all pins are asynchronous to ref_clk and the master never
// needs clock stretching.
`timescale 1ns/1ns
`default_nettype none

module lnbi2c_dev (
	input wire logic ref_clk,
	input wire logic arst_n,
	lnbi2c_if.device bus,
	input wire logic power_good,
	input wire logic addr_pin,
	input wire logic ch1_tone_input_pin,
	input wire logic ch2_tone_input_pin,
	input wire logic ch1_high_volt_pin,
	input wire logic ch2_high_volt_pin,
	input wire logic ch1_overload_in,
	input wire logic ch2_overload_in,
	input wire logic overheat_in,
	output logic ch1_conv_on,
	output logic ch1_ldo_on,
	output logic [1:0] ch1_volt_code,
	output logic ch1_tone_on,
	output logic ch1_limit_high,
	output logic ch2_conv_on,
	output logic ch2_ldo_on,
	output logic [1:0] ch2_volt_code,
	output logic ch2_tone_on,
	output logic ch2_limit_high,
	output logic static_limit
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam int NSYNC = 11;
	// Line bits rest high so no false edge or start follows reset
	localparam logic [NSYNC-1:0] SYNC_IDLE = {2'b11, 9'h000};
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] meta_ff;
	logic [NSYNC-1:0] sync_ff;

	assign raw_in = {bus.scl, bus.sda, power_good, addr_pin,
		ch1_tone_input_pin, ch2_tone_input_pin, ch1_high_volt_pin,
		ch2_high_volt_pin, ch1_overload_in, ch2_overload_in, overheat_in};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					meta_ff[gi] <= SYNC_IDLE[gi];
					sync_ff[gi] <= SYNC_IDLE[gi];
				end else begin
					meta_ff[gi] <= raw_in[gi];
					sync_ff[gi] <= meta_ff[gi];
				end
			end
		end
	endgenerate

	logic scl_s;
	logic sda_s;
	logic pg_s;
	logic addr_s;
	logic tone1_s;
	logic tone2_s;
	logic hv1_s;
	logic hv2_s;
	logic ovl1_s;
	logic ovl2_s;
	logic hot_s;

	assign {scl_s, sda_s, pg_s, addr_s, tone1_s, tone2_s, hv1_s, hv2_s,
		ovl1_s, ovl2_s, hot_s} = sync_ff;

	// ----------------------------------------------------------------
	// Line event detection
	// ----------------------------------------------------------------
	logic scl_d_ff;
	logic sda_d_ff;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise = scl_s & ~scl_d_ff;
	assign scl_fall = ~scl_s & scl_d_ff;
	assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

	// ----------------------------------------------------------------
	// Registers and read-back bytes
	// ----------------------------------------------------------------
	logic [7:lnbi2c_pkg::R1_LOW_WR] reg1_ff;
	logic [7:lnbi2c_pkg::R2_LOW_WR] reg2_ff;
	logic [7:0] byte1;
	logic [7:0] byte2;
	logic [6:0] my_addr;

	assign byte1 = {reg1_ff, ovl1_s};
	assign byte2 = {reg2_ff, hot_s, ovl2_s};
	assign my_addr = addr_s ? lnbi2c_pkg::ADDR_PIN_HIGH
		: lnbi2c_pkg::ADDR_PIN_LOW;

	// ----------------------------------------------------------------
	// Slave protocol engine
	// ----------------------------------------------------------------
	lnbi2c_pkg::lnbi2c_dev_state_e state_ff;
	logic [2:0] cnt_ff;
	logic done_ff;
	logic [7:0] sh_ff;
	logic [7:0] tx_ff;
	logic rw_ff;
	logic rsel_ff;
	logic mack_ff;
	logic sda_oe_ff;
	logic commit;

	// Write lands on the falling edge that ends the eighth data bit
	assign commit = (state_ff == lnbi2c_pkg::D_WR) & scl_fall & done_ff;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= lnbi2c_pkg::D_IDLE;
			cnt_ff <= 3'h0;
			done_ff <= 1'b0;
			sh_ff <= 8'h00;
			tx_ff <= 8'h00;
			rw_ff <= 1'b0;
			rsel_ff <= 1'b0;
			mack_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (!pg_s) begin
			state_ff <= lnbi2c_pkg::D_IDLE;
			sda_oe_ff <= 1'b0;
			cnt_ff <= 3'h0;
			done_ff <= 1'b0;
		end else if (start_det) begin
			state_ff <= lnbi2c_pkg::D_ADDR;
			cnt_ff <= 3'h0;
			done_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (stop_det) begin
			state_ff <= lnbi2c_pkg::D_IDLE;
			sda_oe_ff <= 1'b0;
		end else begin
			case (state_ff)
				lnbi2c_pkg::D_ADDR, lnbi2c_pkg::D_WR: begin
					if (scl_rise) begin
						sh_ff <= {sh_ff[6:0], sda_s};
						cnt_ff <= cnt_ff + 3'h1;
						done_ff <= (cnt_ff == lnbi2c_pkg::BYTE_LAST_CNT);
					end else if (scl_fall && done_ff) begin
						done_ff <= 1'b0;
						if (state_ff == lnbi2c_pkg::D_WR) begin
							state_ff <= lnbi2c_pkg::D_WACK;
							sda_oe_ff <= 1'b1;
						end else if (sh_ff[7:1] == my_addr) begin
							state_ff <= lnbi2c_pkg::D_AACK;
							sda_oe_ff <= 1'b1;
							rw_ff <= sh_ff[0];
						end else begin
							// Other addresses: stay off the bus until next start
							state_ff <= lnbi2c_pkg::D_IDLE;
						end
					end
				end
				lnbi2c_pkg::D_AACK: begin
					if (scl_fall) begin
						if (rw_ff) begin
							state_ff <= lnbi2c_pkg::D_RD;
							rsel_ff <= 1'b0;
							sda_oe_ff <= ~byte1[7];
							tx_ff <= {byte1[6:0], 1'b0};
						end else begin
							state_ff <= lnbi2c_pkg::D_WR;
							sda_oe_ff <= 1'b0;
						end
					end
				end
				lnbi2c_pkg::D_WACK: begin
					if (scl_fall) begin
						// Further bytes in one write are taken the same way
						state_ff <= lnbi2c_pkg::D_WR;
						sda_oe_ff <= 1'b0;
					end
				end
				lnbi2c_pkg::D_RD: begin
					if (scl_rise) begin
						cnt_ff <= cnt_ff + 3'h1;
						done_ff <= (cnt_ff == lnbi2c_pkg::BYTE_LAST_CNT);
					end else if (scl_fall) begin
						if (done_ff) begin
							done_ff <= 1'b0;
							sda_oe_ff <= 1'b0;
							state_ff <= lnbi2c_pkg::D_RACK;
						end else begin
							sda_oe_ff <= ~tx_ff[7];
							tx_ff <= {tx_ff[6:0], 1'b0};
						end
					end
				end
				lnbi2c_pkg::D_RACK: begin
					if (scl_rise) begin
						mack_ff <= ~sda_s;
					end else if (scl_fall) begin
						if (mack_ff) begin
							state_ff <= lnbi2c_pkg::D_RD;
							rsel_ff <= ~rsel_ff;
							sda_oe_ff <= rsel_ff ? ~byte1[7] : ~byte2[7];
							tx_ff <= rsel_ff ? {byte1[6:0], 1'b0}
								: {byte2[6:0], 1'b0};
						end else begin
							state_ff <= lnbi2c_pkg::D_IDLE;
						end
					end
				end
				lnbi2c_pkg::D_IDLE: begin
					sda_oe_ff <= 1'b0;
				end
				default: begin
					state_ff <= lnbi2c_pkg::D_IDLE;
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = sda_oe_ff;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	// Overheat wins over a write in the same cycle: data must stay cleared
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg1_ff <= lnbi2c_pkg::REG_RESET[7:lnbi2c_pkg::R1_LOW_WR];
			reg2_ff <= lnbi2c_pkg::REG_RESET[7:lnbi2c_pkg::R2_LOW_WR];
		end else if (!pg_s || hot_s) begin
			reg1_ff <= lnbi2c_pkg::REG_RESET[7:lnbi2c_pkg::R1_LOW_WR];
			reg2_ff <= lnbi2c_pkg::REG_RESET[7:lnbi2c_pkg::R2_LOW_WR];
		end else if (commit) begin
			if (!sh_ff[lnbi2c_pkg::SEL_BIT]) begin
				reg1_ff <= sh_ff[7:lnbi2c_pkg::R1_LOW_WR];
			end else begin
				reg2_ff <= sh_ff[7:lnbi2c_pkg::R2_LOW_WR];
			end
		end
	end

	// ----------------------------------------------------------------
	// Power block controls
	// ----------------------------------------------------------------
	logic on1;
	logic on2;
	assign on1 = reg1_ff[lnbi2c_pkg::R1_ON] & ~hot_s;
	assign on2 = reg2_ff[lnbi2c_pkg::R2_ON] & ~hot_s;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ch1_conv_on <= 1'b0;
			ch1_ldo_on <= 1'b0;
			ch1_volt_code <= 2'h0;
			ch1_tone_on <= 1'b0;
			ch1_limit_high <= 1'b0;
			ch2_conv_on <= 1'b0;
			ch2_ldo_on <= 1'b0;
			ch2_volt_code <= 2'h0;
			ch2_tone_on <= 1'b0;
			ch2_limit_high <= 1'b0;
			static_limit <= 1'b0;
		end else begin
			ch1_conv_on <= on1;
			ch1_ldo_on <= on1;
			ch2_conv_on <= on2;
			ch2_ldo_on <= on2;
			ch1_volt_code <= hv1_s ? lnbi2c_pkg::VOUT_18V
				: {reg1_ff[lnbi2c_pkg::R1_COMP],
				reg1_ff[lnbi2c_pkg::R1_VPICK]};
			ch2_volt_code <= hv2_s ? lnbi2c_pkg::VOUT_18V
				: {reg2_ff[lnbi2c_pkg::R2_COMP],
				reg2_ff[lnbi2c_pkg::R2_VPICK]};
			ch1_tone_on <= on1 & (reg1_ff[lnbi2c_pkg::R1_TONE]
				| tone1_s);
			ch2_tone_on <= on2 & (reg2_ff[lnbi2c_pkg::R2_TONE]
				| tone2_s);
			ch1_limit_high <= reg1_ff[lnbi2c_pkg::R1_ISEL];
			ch2_limit_high <= reg2_ff[lnbi2c_pkg::R2_ISEL];
			static_limit <= reg1_ff[lnbi2c_pkg::R1_STATIC];
		end
	end

endmodule // lnbi2c_dev

`default_nettype wire

// ===== logic/lnbi2c_host.sv
// Controller end: I2C master driven through a small register port.
// Assumes the device never stretches the clock; SCL is made here by
// dividing ref_clk.
`timescale 1ns/1ns
`default_nettype none

module lnbi2c_host #(
	parameter int QTR_CYC = lnbi2c_pkg::SCL_QTR_CYC
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	lnbi2c_if.host bus,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);

	// ----------------------------------------------------------------
	// Data line synchroniser
	// ----------------------------------------------------------------
	logic sda_meta_ff;
	logic sda_s_ff;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sda_meta_ff <= 1'b1;
			sda_s_ff <= 1'b1;
		end else begin
			sda_meta_ff <= bus.sda;
			sda_s_ff <= sda_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// Command and status registers
	// ----------------------------------------------------------------
	lnbi2c_pkg::lnbi2c_host_state_e state_ff;
	logic go;
	logic [31:0] cmd_ff;
	logic nack_ff;
	logic [31:0] rdbuf_ff;

	// Commands written while busy are dropped; software polls busy
	assign go = reg_wr & (reg_addr == lnbi2c_pkg::HREG_CMD)
		& (state_ff == lnbi2c_pkg::H_IDLE);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_ff <= 32'h0000_0000;
		end else if (go) begin
			cmd_ff <= reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				lnbi2c_pkg::HREG_CMD: reg_rdata <= cmd_ff;
				lnbi2c_pkg::HREG_STAT: begin
					reg_rdata <= 32'h0000_0000;
					reg_rdata[lnbi2c_pkg::STAT_BUSY] <=
						(state_ff != lnbi2c_pkg::H_IDLE);
					reg_rdata[lnbi2c_pkg::STAT_NACK] <= nack_ff;
				end
				lnbi2c_pkg::HREG_RDATA: reg_rdata <= rdbuf_ff;
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Quarter-bit tick divider
	// ----------------------------------------------------------------
	logic [15:0] div_ff;
	logic tick;
	assign tick = (div_ff == 16'(QTR_CYC - 1));

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_ff <= 16'h0000;
		end else if (go || tick) begin
			div_ff <= 16'h0000;
		end else begin
			div_ff <= div_ff + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Master sequencer
	// ----------------------------------------------------------------
	logic [1:0] q_ff;
	logic [3:0] idx_ff;
	logic [7:0] tx_ff;
	logic [7:0] rx_ff;
	logic second_ff;
	logic [1:0] left_ff;
	logic scl_oe_ff;
	logic sda_oe_ff;
	logic last_bit;
	assign last_bit = (idx_ff == lnbi2c_pkg::LAST_BIT_IDX);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= lnbi2c_pkg::H_IDLE;
			q_ff <= 2'h0;
			idx_ff <= 4'h0;
			tx_ff <= 8'h00;
			rx_ff <= 8'h00;
			second_ff <= 1'b0;
			left_ff <= 2'h0;
			nack_ff <= 1'b0;
			rdbuf_ff <= 32'h0000_0000;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (go) begin
			state_ff <= lnbi2c_pkg::H_START;
			q_ff <= 2'h0;
			nack_ff <= 1'b0;
			rdbuf_ff <= 32'h0000_0000;
			tx_ff <= reg_wdata[lnbi2c_pkg::CMD_ABYTE_LSB +: 8];
			left_ff <= reg_wdata[lnbi2c_pkg::CMD_RCNT_LSB +: 2];
		end else if (tick && state_ff != lnbi2c_pkg::H_IDLE) begin
			q_ff <= q_ff + 2'h1;
			case (state_ff)
				lnbi2c_pkg::H_START: begin
					if (q_ff == lnbi2c_pkg::Q_RISE) begin
						sda_oe_ff <= 1'b1;
					end else if (q_ff == lnbi2c_pkg::Q_FALL) begin
						scl_oe_ff <= 1'b1;
						idx_ff <= 4'h0;
						second_ff <= 1'b0;
						state_ff <= lnbi2c_pkg::H_SEND;
					end
				end
				lnbi2c_pkg::H_SEND: begin
					case (q_ff)
						lnbi2c_pkg::Q_DRIVE: begin
							sda_oe_ff <= last_bit ? 1'b0 : ~tx_ff[7];
							tx_ff <= {tx_ff[6:0], 1'b0};
						end
						lnbi2c_pkg::Q_RISE: scl_oe_ff <= 1'b0;
						lnbi2c_pkg::Q_SAMPLE: begin
							if (last_bit) begin
								nack_ff <= sda_s_ff;
							end
						end
						default: begin
							scl_oe_ff <= 1'b1;
							idx_ff <= last_bit ? 4'h0 : idx_ff + 4'h1;
							if (last_bit) begin
								if (nack_ff || second_ff) begin
									state_ff <= lnbi2c_pkg::H_STOP;
								end else if (cmd_ff[lnbi2c_pkg::CMD_ABYTE_LSB]) begin
									state_ff <= lnbi2c_pkg::H_RECV;
								end else begin
									tx_ff <= cmd_ff[lnbi2c_pkg::CMD_WDATA_LSB +: 8];
									second_ff <= 1'b1;
								end
							end
						end
					endcase
				end
				lnbi2c_pkg::H_RECV: begin
					case (q_ff)
						lnbi2c_pkg::Q_DRIVE: begin
							sda_oe_ff <= last_bit & (left_ff != 2'h0);
						end
						lnbi2c_pkg::Q_RISE: scl_oe_ff <= 1'b0;
						lnbi2c_pkg::Q_SAMPLE: begin
							if (!last_bit) begin
								rx_ff <= {rx_ff[6:0], sda_s_ff};
							end
						end
						default: begin
							scl_oe_ff <= 1'b1;
							idx_ff <= last_bit ? 4'h0 : idx_ff + 4'h1;
							if (last_bit) begin
								rdbuf_ff <= {rdbuf_ff[23:0], rx_ff};
								if (left_ff != 2'h0) begin
									left_ff <= left_ff - 2'h1;
								end else begin
									state_ff <= lnbi2c_pkg::H_STOP;
								end
							end
						end
					endcase
				end
				lnbi2c_pkg::H_STOP: begin
					case (q_ff)
						lnbi2c_pkg::Q_DRIVE: sda_oe_ff <= 1'b1;
						lnbi2c_pkg::Q_RISE: scl_oe_ff <= 1'b0;
						lnbi2c_pkg::Q_SAMPLE: sda_oe_ff <= 1'b0;
						default: state_ff <= lnbi2c_pkg::H_IDLE;
					endcase
				end
				default: state_ff <= lnbi2c_pkg::H_IDLE;
			endcase
		end
	end

	assign bus.host_scl_o = 1'b0;
	assign bus.host_scl_oe = scl_oe_ff;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe = sda_oe_ff;

endmodule // lnbi2c_host

`default_nettype wire

// ===== dv/lnbi2c_monitor.sv
// Link checker for the two-wire bus between host and device ends.
// Assumes QTR_CYC of 8 on the host, so each SCL half lasts 16 cycles.
`timescale 1ns/1ns
`default_nettype none

module lnbi2c_monitor (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic power_good,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);
	// ----------------------------------------
	// Link properties
	// ----------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence s_hi_hold;
		scl[*8];
	endsequence

	sequence s_lo_hold;
		(!scl)[*8];
	endsequence

	a_start_by_host: assert property ($fell(sda) && scl |-> host_sda_oe && !dev_sda_oe)
		else $error("device made a start");
	a_stop_by_host: assert property ($rose(sda) && scl |-> !$past(dev_sda_oe))
		else $error("device released sda with scl high");
	a_scl_high_len: assert property ($rose(scl) |-> s_hi_hold)
		else $error("scl high phase too short");
	a_scl_low_len: assert property ($fell(scl) |-> s_lo_hold)
		else $error("scl low phase too short");
	a_dev_on_low: assert property ($rose(dev_sda_oe) |-> !scl)
		else $error("device pulled sda with scl high");
	a_dev_hold_bit: assert property (dev_sda_oe && $rose(scl) |-> dev_sda_oe[*8])
		else $error("device let go during scl high");
	a_dev_lets_go: assert property ($rose(dev_sda_oe) |-> ##[1:300] !dev_sda_oe)
		else $error("device held sda too long");
	a_pg_silent: assert property ((!power_good)[*4] |-> !dev_sda_oe)
		else $error("device drove sda without power good");
endmodule // lnbi2c_monitor

`default_nettype wire

// ===== dv/dual_lnb_i2c_control_regs_tb_top.sv
// Bench: host end drives the device end over the link, checked at ports.
// Assumes the host register map and 100 MHz ref_clk from the package.
`timescale 1ns/1ns
`default_nettype none

module dual_lnb_i2c_control_regs_tb_top;
	// ----------------------------------------
	// Signals, ends and checker
	// ----------------------------------------
	logic ref_clk = 1'b0, arst_n = 1'b0, power_good = 1'b0, apin = 1'b0;
	logic ot = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, chk_on = 1'b0;
	logic [1:0] tin = 2'h0, hv = 2'h0, ol = 2'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, got;
	logic [12:0] po;
	logic [7:0] r1 = 8'h00, r2 = 8'h00, d;
	logic [6:0] adr = lnbi2c_pkg::ADDR_PIN_LOW;
	logic nk;
	logic [31:0] exp_q[$];
	int miscompares = 0, cmp_count = 0, seed = 32'h8a47;

	always #5 ref_clk = ~ref_clk;

	lnbi2c_if bus ();
	lnbi2c_host #(.QTR_CYC(8)) u_lnbi2c_host (.ref_clk(ref_clk),
		.arst_n(arst_n), .bus(bus), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	lnbi2c_dev u_lnbi2c_dev (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus),
		.power_good(power_good), .addr_pin(apin),
		.ch1_tone_input_pin(tin[0]), .ch2_tone_input_pin(tin[1]),
		.ch1_high_volt_pin(hv[0]), .ch2_high_volt_pin(hv[1]),
		.ch1_overload_in(ol[0]), .ch2_overload_in(ol[1]), .overheat_in(ot),
		.ch1_conv_on(po[12]), .ch1_ldo_on(po[11]), .ch1_volt_code(po[10:9]),
		.ch1_tone_on(po[8]), .ch1_limit_high(po[7]), .ch2_conv_on(po[6]),
		.ch2_ldo_on(po[5]), .ch2_volt_code(po[4:3]), .ch2_tone_on(po[2]),
		.ch2_limit_high(po[1]), .static_limit(po[0]));
	lnbi2c_monitor u_lnbi2c_monitor (.ref_clk(ref_clk), .arst_n(arst_n),
		.power_good(power_good), .scl(bus.scl), .sda(bus.sda),
		.host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe));

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task automatic summarize;
		$display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Read data stands one cycle only, so it is caught at the falling edge
	always @(posedge ref_clk) rd_d <= reg_rd & chk_on;
	always @(negedge ref_clk) begin
		if (rd_d)
			chk(reg_rdata, exp_q.pop_front());
	end

	// Two cycles per access keeps strobes from being assigned twice
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] x);
		reg_addr <= a;
		reg_wdata <= x;
		reg_wr <= w;
		reg_rd <= ~w;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 got = reg_rdata;
		@(posedge ref_clk);
	endtask

	task automatic xfer(input logic [7:0] ab, input logic [7:0] wd,
		input logic [1:0] n);
		int i;
		acc(1'b1, lnbi2c_pkg::HREG_CMD, {14'h0, n, wd, ab});
		for (i = 0; i < 5000; i++) begin
			acc(1'b0, lnbi2c_pkg::HREG_STAT, 32'h0);
			if (got[lnbi2c_pkg::STAT_BUSY] === 1'b0)
				break;
		end
		if (i == 5000) begin
			miscompares++;
			summarize;
		end
		nk = got[lnbi2c_pkg::STAT_NACK];
	endtask

	task automatic wrreg(input logic [7:0] x);
		xfer({adr, 1'b0}, x, 2'h0);
		chk({31'h0, nk}, 32'h0);
		if (x[7])
			r2[7:2] = x[7:2];
		else
			r1[7:1] = x[7:1];
		repeat (6) @(posedge ref_clk);
		chk({19'h0, po}, {19'h0, r1[1] & ~ot, r1[1] & ~ot,
			hv[0] ? 2'h1 : r1[3:2], r1[1] & ~ot & (r1[4] | tin[0]), r1[5],
			r2[2] & ~ot, r2[2] & ~ot, hv[1] ? 2'h1 : r2[4:3],
			r2[2] & ~ot & (r2[5] | tin[1]), r2[6], r1[6]});
	endtask

	// Four bytes: channel one, two, one, two
	task automatic rdregs;
		logic [7:0] e1, e2;
		e1 = {r1[7:1], ol[0]};
		e2 = {r2[7:2], ot, ol[1]};
		xfer({adr, 1'b1}, 8'h00, 2'h3);
		chk_on = 1'b1;
		exp_q.push_back({e1, e2, e1, e2});
		acc(1'b0, lnbi2c_pkg::HREG_RDATA, 32'h0);
		chk_on = 1'b0;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		xfer(8'h10, 8'h02, 2'h0);
		chk({31'h0, nk}, 32'h1);
		power_good <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rdregs;
		for (int k = 0; k < 8; k++) begin
			{ol, tin, hv} <= 6'($random(seed));
			d = 8'($random(seed));
			wrreg(d);
			rdregs;
		end
		apin <= 1'b1;
		xfer(8'h10, 8'h00, 2'h0);
		chk({31'h0, nk}, 32'h1);
		adr = lnbi2c_pkg::ADDR_PIN_HIGH;
		wrreg(8'h2b);
		ot <= 1'b1;
		r1 = 8'h00;
		r2 = 8'h00;
		repeat (8) @(posedge ref_clk);
		rdregs;
		ot <= 1'b0;
		wrreg(8'hbe);
		power_good <= 1'b0;
		hv <= 2'h0;
		r2 = 8'h00;
		repeat (8) @(posedge ref_clk);
		chk({19'h0, po}, 32'h0);
		power_good <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rdregs;
		summarize;
	end
endmodule // dual_lnb_i2c_control_regs_tb_top

`default_nettype wire
